// ### design/uctx_buf.sv
// Two-entry valid/ready buffer; head word comes from a register
// Assumes fill and drain share one clock
`timescale 1ns/100ps
module uctx_buf
	import uctx_pkg::*;
#(
	parameter int W = 9
) (
	input  wire logic clk,
	input  wire logic srst,
	uctx_stream_if.dst fill,
	uctx_stream_if.src drain
);
	if (W < 1) begin : g_chk
		$error("uctx_buf: width must be at least one");
	end

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0]        cnt;
	} uctx_buf_s;

	uctx_buf_s q;
	uctx_buf_s next_q;
	logic      push;
	logic      pop;

	assign fill.ready  = (q.cnt != 2'h2);
	assign drain.valid = (q.cnt != 2'h0);
	assign drain.data  = q.mem[0];
	assign push        = fill.valid && fill.ready;
	assign pop         = drain.valid && drain.ready;

	// Pop shifts entry one forward so the head stays registered
	always_comb begin
		next_q = q;
		if (pop) begin
			next_q.mem[0] = q.mem[1];
		end
		if (push) begin
			if (pop) begin
				// Push with pop only occurs while one entry is held
				next_q.mem[0] = fill.data;
			end else begin
				next_q.mem[q.cnt[0]] = fill.data;
			end
		end
		next_q.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule

// ### design/uctx_map.svh
// Field positions, encodings, widths, reset values and timing counts of the serial transmitter
// Assumes inclusion by bare name from the design files only
`ifndef UCTX_MAP_SVH
`define UCTX_MAP_SVH

// -----------------------------------------------------------------
// Clocking
// -----------------------------------------------------------------
`define UCTX_SYS_CLK_PERIOD_NS 25
`define UCTX_OVS_NORMAL        5'h10
`define UCTX_OVS_DOUBLE        5'h08
`define UCTX_SYNC_DIV          2

// -----------------------------------------------------------------
// Frame format fields
// -----------------------------------------------------------------
`define UCTX_SIZE_5BIT         3'h0
`define UCTX_SIZE_9BIT         3'h7
`define UCTX_BITS_BASE         4'h5
`define UCTX_BITS_MAX          4'h9
`define UCTX_BITS_DEFAULT      4'h8
`define UCTX_PAR_EN_POS        1
`define UCTX_PAR_ODD_POS       0
`define UCTX_FRAME_W           13
`define UCTX_START_LVL         1'b0
`define UCTX_IDLE_LVL          1'b1

// -----------------------------------------------------------------
// Buffer and reset values
// -----------------------------------------------------------------
`define UCTX_DATA_W            9
`define UCTX_BUF_DEPTH         2
`define UCTX_RST_EMPTY_FLAG    1'b1
`define UCTX_RST_DONE_FLAG     1'b0

`endif

// ### design/uctx_pkg.sv
// Types shared by the serial transmitter modules
// Assumes uctx_map.svh is compiled alongside
package uctx_pkg;

	typedef enum logic {
		UCTX_IDLE,
		UCTX_SHIFT
	} uctx_tx_state_e;

	typedef struct packed {
		logic       sync;
		logic       master;
		logic       spi;
		logic       cpol;
		logic [3:0] nbits;
		logic       par_en;
		logic       par_odd;
		logic       stop2;
	} uctx_fmt_s;

endpackage

// ### design/uctx_stream_if.sv
// Valid/ready word carrier between the transmitter and its buffer
// Assumes both ends sit on the same clock
`timescale 1ns/100ps
interface uctx_stream_if #(parameter int W = 9);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport dst (input valid, input data, output ready);
endinterface

// ### design/uctx_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
// Assumes an asynchronous pin input and one system clock
`timescale 1ns/100ps
module uctx_sync
	import uctx_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic pin,
	output logic      lvl,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic f1;
		logic f2;
		logic f3;
		logic lvl;
	} uctx_sync_s;

	uctx_sync_s q;
	uctx_sync_s next_q;

	// Level moves only once stages two and three agree
	always_comb begin
		next_q     = q;
		next_q.f1  = pin;
		next_q.f2  = q.f1;
		next_q.f3  = q.f2;
		if (q.f2 == q.f3) begin
			next_q.lvl = q.f3;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			q <= next_q;
		end
	end

	assign lvl  = q.lvl;
	assign rise = (q.f2 == q.f3) && q.f3 && !q.lvl;
	assign fall = (q.f2 == q.f3) && !q.f3 && q.lvl;
endmodule

// ### design/uctx_top.sv
// Serial port clock generator, frame builder and transmit path
// Assumes control bits held stable by software outside frames; one 40 MHz clock
//
// Overview of operation
// RQ1 - Async normal bit rate is clock over sixteen times divisor plus one
// RQ2 - Double speed async bit rate is clock over eight times divisor plus one
// RQ3 - Master serial clock is clock over two times divisor plus one
// RQ4 - Mode bit picks async or sync; SPI reuses sync clocking
// RQ5 - Master bit drives serial clock pin out, else pin is an input
// RQ6 - Serial clock pin only used in sync or SPI modes
// RQ7 - External clock is synchronised and edge detected; peer keeps it slow
// RQ8 - Input sampled on the edge opposite to the data change edge
// RQ9 - Polarity zero: change on rising, sample on falling; one swaps
// RQ10 - All thirty formats of size, parity and stop count supported
// RQ11 - Start bit, data LSB first, parity, then stop bits
// RQ12 - Line idles high, start bit low, frames may follow back to back
// RQ13 - Size, parity and stop fields form one format shared with receiver
// RQ14 - Parity is xor of data bits, inverted for odd
// RQ15 - Transmit enable hands the output pin to the transmitter
// RQ16 - Slave select is input as SPI slave, optional output as master
// RQ17 - Data write loads buffer; shifter takes it when idle or after stop
// RQ18 - Ninth bit is set by software before the data write
// RQ19 - Empty flag follows buffer; writing zero clears, one does nothing
// RQ20 - Empty interrupt while flag, its enable and global enable set
// RQ21 - Complete flag set when frame out and buffer empty; cleared on service
// RQ22 - Complete interrupt while flag, its enable and global enable set
// RQ23 - Disable waits for the frame in progress to finish
// RQ24 - Parity only when upper parity bit set, after the MSB
// RQ25 - Size codes zero to three give five to eight bits; stops high
`timescale 1ns/100ps
`include "uctx_map.svh"
module uctx_top
	import uctx_pkg::*;
#(
	parameter int BAUD_W = 12
) (
	input  wire logic              SYS_CLK,
	input  wire logic              SRST,
	input  wire logic              SYNC_MODE_SELECT,
	input  wire logic              SPI_MODE_SELECT,
	input  wire logic              MASTER_SELECT,
	input  wire logic              DOUBLE_SPEED_SELECT,
	input  wire logic              CLOCK_POLARITY_SELECT,
	input  wire logic [2:0]        CHAR_SIZE_FIELD,
	input  wire logic [1:0]        PARITY_MODE_FIELD,
	input  wire logic              STOP_BITS_SELECT,
	input  wire logic              TRANSMIT_ENABLE_BIT,
	input  wire logic              SEL_OUTPUT_ENABLE,
	input  wire logic              TX_NINTH_BIT,
	input  wire logic [BAUD_W-1:0] BAUD_DIVISOR,
	input  wire logic              DATA_WR,
	input  wire logic [7:0]        DATA_IN,
	output logic                   DATA_READY,
	input  wire logic              STATUS_WR,
	input  wire logic              STATUS_WR_EMPTY,
	input  wire logic              STATUS_WR_DONE,
	input  wire logic              DONE_INT_ACK,
	input  wire logic              GLOBAL_INT_ENABLE,
	input  wire logic              TX_EMPTY_INT_ENABLE,
	input  wire logic              TX_COMPLETE_INT_ENABLE,
	output logic                   TX_BUFFER_EMPTY_FLAG,
	output logic                   TX_COMPLETE_FLAG,
	output logic                   TX_EMPTY_IRQ,
	output logic                   TX_COMPLETE_IRQ,
	output logic                   TXD_OUT,
	output logic                   TXD_OE,
	input  wire logic              SERIAL_CLOCK_IN,
	output logic                   SERIAL_CLOCK_OUT,
	output logic                   SERIAL_CLOCK_OE,
	input  wire logic              SLAVE_SEL_IN,
	output logic                   SLAVE_SEL_OUT,
	output logic                   SLAVE_SEL_OE,
	output logic                   BAUD_TICK,
	output logic                   SAMPLE_EDGE,
	output logic [3:0]             FRAME_DATA_BITS
);
	if (BAUD_W < 2 || BAUD_W > 16) begin : g_chk
		$error("uctx_top: divisor width must lie in 2..16");
	end

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [BAUD_W-1:0]       pre;
		logic [4:0]              sub;
		logic                    serial_clock_pin;
		uctx_tx_state_e          st;
		logic                    active;
		logic                    txd;
		logic [`UCTX_FRAME_W-1:0] sreg;
		logic [3:0]              cnt;
		logic                    tx_buffer_empty_flag;
		logic                    tx_complete_flag;
		logic                    empty_d;
	} uctx_top_s;

	uctx_top_s q;
	uctx_top_s next_q;

	uctx_stream_if #(.W(`UCTX_DATA_W)) wr_if ();
	uctx_stream_if #(.W(`UCTX_DATA_W)) rd_if ();

	uctx_fmt_s                fmt;
	logic                     pre_tick;
	logic [4:0]               ovs_last;
	logic                     async_tick;
	logic                     m_run;
	logic                     m_rise;
	logic                     m_fall;
	logic                     s_lvl;
	logic                     s_rise;
	logic                     s_fall;
	logic                     ss_lvl;
	logic                     e_rise;
	logic                     e_fall;
	logic                     slave_gate;
	logic                     chg_edge;
	logic                     smp_edge;
	logic                     shift_tick;
	logic                     busy;
	logic                     done;
	logic                     can_load;
	logic                     buf_empty;
	logic                     tx_buffer_empty_flag_clr;
	logic                     txc_clr;
	logic                     txc_set;
	logic [`UCTX_FRAME_W-1:0] frame;
	logic [3:0]               frame_cnt;
	logic                     par_bit;
	logic [`UCTX_DATA_W-1:0]  par_mask;

	// -----------------------------------------------------------------
	// Shared frame format
	// -----------------------------------------------------------------
	// RQ13 shared format decode
	always_comb begin
		fmt.sync    = SYNC_MODE_SELECT;
		fmt.master  = MASTER_SELECT;
		fmt.spi     = SPI_MODE_SELECT && SYNC_MODE_SELECT;
		fmt.cpol    = CLOCK_POLARITY_SELECT;
		fmt.par_en  = PARITY_MODE_FIELD[`UCTX_PAR_EN_POS];
		fmt.par_odd = PARITY_MODE_FIELD[`UCTX_PAR_ODD_POS];
		fmt.stop2   = STOP_BITS_SELECT;
		// RQ25 size code decode
		if (CHAR_SIZE_FIELD == `UCTX_SIZE_9BIT) begin
			fmt.nbits = `UCTX_BITS_MAX;
		end else if (CHAR_SIZE_FIELD[2] == 1'b0) begin
			fmt.nbits = `UCTX_BITS_BASE + {2'h0, CHAR_SIZE_FIELD[1:0]};
		end else begin
			fmt.nbits = `UCTX_BITS_DEFAULT;
		end
	end
	assign FRAME_DATA_BITS = fmt.nbits;

	// -----------------------------------------------------------------
	// Baud generator and serial clock
	// -----------------------------------------------------------------
	assign pre_tick = (q.pre == '0);
	// RQ2 double speed oversampling
	assign ovs_last = DOUBLE_SPEED_SELECT ? (`UCTX_OVS_DOUBLE - 5'h01)
	                                      : (`UCTX_OVS_NORMAL - 5'h01);
	// RQ1 sixteen ticks per bit
	assign async_tick = pre_tick && (q.sub == ovs_last);
	// RQ3 master clock toggles each tick
	assign m_run  = fmt.sync && fmt.master;
	assign m_rise = m_run && pre_tick && !q.serial_clock_pin;
	assign m_fall = m_run && pre_tick && q.serial_clock_pin;

	// RQ7 external clock synchroniser
	uctx_sync #(.RST_VAL(1'b0)) u_clk_sync (
		.clk  (SYS_CLK),
		.srst (SRST),
		.pin  (SERIAL_CLOCK_IN),
		.lvl  (s_lvl),
		.rise (s_rise),
		.fall (s_fall)
	);

	uctx_sync #(.RST_VAL(1'b1)) u_sel_sync (
		.clk  (SYS_CLK),
		.srst (SRST),
		.pin  (SLAVE_SEL_IN),
		.lvl  (ss_lvl),
		.rise (),
		.fall ()
	);

	// RQ16 slave select gates slave edges
	assign slave_gate = !fmt.spi || fmt.master || !ss_lvl;
	// RQ4 source pick by mode
	assign e_rise = fmt.master ? m_rise : (s_rise && slave_gate && fmt.sync);
	assign e_fall = fmt.master ? m_fall : (s_fall && slave_gate && fmt.sync);
	// RQ9 polarity swaps edges
	assign chg_edge = fmt.cpol ? e_fall : e_rise;
	// RQ8 sample on opposite edge
	assign smp_edge = fmt.cpol ? e_rise : e_fall;

	assign shift_tick  = fmt.sync ? chg_edge : async_tick;
	assign BAUD_TICK   = pre_tick;
	assign SAMPLE_EDGE = fmt.sync && smp_edge;

	// RQ5 master drives clock pin
	assign SERIAL_CLOCK_OUT = q.serial_clock_pin;
	// RQ6 pin left alone in async
	assign SERIAL_CLOCK_OE  = m_run;
	// RQ16 optional select output
	assign SLAVE_SEL_OE  = fmt.spi && fmt.master && SEL_OUTPUT_ENABLE;
	assign SLAVE_SEL_OUT = !busy;

	// -----------------------------------------------------------------
	// Transmit buffer
	// -----------------------------------------------------------------
	// RQ18 ninth bit taken with the data write
	assign wr_if.valid = DATA_WR;
	assign wr_if.data  = {TX_NINTH_BIT, DATA_IN};
	assign DATA_READY  = wr_if.ready;

	// Two entries let a slow drain hold a word without losing the next write
	uctx_buf #(.W(`UCTX_DATA_W)) u_buf (
		.clk   (SYS_CLK),
		.srst  (SRST),
		.fill  (wr_if),
		.drain (rd_if)
	);

	assign buf_empty = !rd_if.valid;
	assign busy      = (q.st == UCTX_SHIFT);
	assign done      = busy && shift_tick && (q.cnt == 4'h0);
	// RQ17 load when idle or after last stop
	assign can_load  = TRANSMIT_ENABLE_BIT && rd_if.valid && (!busy || done);
	assign rd_if.ready = can_load;

	// -----------------------------------------------------------------
	// Frame builder
	// -----------------------------------------------------------------
	always_comb begin
		frame    = '1;
		par_mask = '0;
		// RQ12 start bit low
		frame[0] = `UCTX_START_LVL;
		// RQ11 data LSB first
		for (int i = 0; i < `UCTX_DATA_W; i++) begin
			if (i < int'(fmt.nbits)) begin
				frame[i + 1] = rd_if.data[i];
				par_mask[i]  = 1'b1;
			end
		end
		// RQ14 xor, inverted when odd
		par_bit = (^(rd_if.data & par_mask)) ^ fmt.par_odd;
		// RQ24 parity after the MSB
		if (fmt.par_en) begin
			frame[fmt.nbits + 4'h1] = par_bit;
		end
		// RQ10 bit count per format
		frame_cnt = fmt.nbits + {3'h0, fmt.par_en} + {3'h0, fmt.stop2} + 4'h1;
	end

	// -----------------------------------------------------------------
	// Shifter and flags
	// -----------------------------------------------------------------
	// RQ19 write zero clears, one ignored
	assign tx_buffer_empty_flag_clr = STATUS_WR && !STATUS_WR_EMPTY;
	// RQ21 cleared on service or zero write
	assign txc_clr  = DONE_INT_ACK || (STATUS_WR && !STATUS_WR_DONE);
	assign txc_set  = done && buf_empty;

	always_comb begin
		next_q = q;
		next_q.pre = pre_tick ? BAUD_DIVISOR : (q.pre - 1'b1);
		if (pre_tick) begin
			next_q.sub = (q.sub == ovs_last) ? 5'h00 : (q.sub + 5'h01);
		end
		if (m_run) begin
			if (pre_tick) begin
				next_q.serial_clock_pin = !q.serial_clock_pin;
			end
		end else begin
			next_q.serial_clock_pin = fmt.cpol;
		end
		if (busy && shift_tick && q.cnt != 4'h0) begin
			next_q.txd  = q.sreg[0];
			next_q.sreg = {`UCTX_IDLE_LVL, q.sreg[`UCTX_FRAME_W-1:1]};
			next_q.cnt  = q.cnt - 4'h1;
		end
		if (can_load) begin
			next_q.st   = UCTX_SHIFT;
			next_q.txd  = frame[0];
			next_q.sreg = {`UCTX_IDLE_LVL, frame[`UCTX_FRAME_W-1:1]};
			next_q.cnt  = frame_cnt;
			next_q.sub  = 5'h00;
		end else if (done) begin
			// RQ12 line returns high
			next_q.st  = UCTX_IDLE;
			next_q.txd = `UCTX_IDLE_LVL;
		end
		// RQ23 disable waits for frame end
		next_q.active = TRANSMIT_ENABLE_BIT || (next_q.st == UCTX_SHIFT);
		// RQ19 set on empty, set beats clear
		next_q.empty_d = buf_empty;
		if (buf_empty && !q.empty_d) begin
			next_q.tx_buffer_empty_flag = 1'b1;
		end else if (!buf_empty || tx_buffer_empty_flag_clr) begin
			next_q.tx_buffer_empty_flag = 1'b0;
		end
		// RQ21 set beats clear
		if (txc_set) begin
			next_q.tx_complete_flag = 1'b1;
		end else if (txc_clr) begin
			next_q.tx_complete_flag = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			q         <= '0;
			q.txd     <= `UCTX_IDLE_LVL;
			q.tx_buffer_empty_flag    <= `UCTX_RST_EMPTY_FLAG;
			q.tx_complete_flag     <= `UCTX_RST_DONE_FLAG;
			q.empty_d <= 1'b1;
			q.st      <= UCTX_IDLE;
		end else begin
			q <= next_q;
		end
	end

	// RQ15 pin handed to transmitter
	assign TXD_OE  = q.active;
	assign TXD_OUT = q.txd;
	assign TX_BUFFER_EMPTY_FLAG = q.tx_buffer_empty_flag;
	assign TX_COMPLETE_FLAG     = q.tx_complete_flag;
	// RQ20 empty interrupt level
	assign TX_EMPTY_IRQ    = q.tx_buffer_empty_flag && TX_EMPTY_INT_ENABLE && GLOBAL_INT_ENABLE;
	// RQ22 complete interrupt level
	assign TX_COMPLETE_IRQ = q.tx_complete_flag && TX_COMPLETE_INT_ENABLE && GLOBAL_INT_ENABLE;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);

	logic [BAUD_W:0] gap;
	logic            gap_ok;
	always_ff @(posedge SYS_CLK) begin
		if (SRST || pre_tick) begin
			gap <= '0;
		end else begin
			gap <= gap + 1'b1;
		end
		// A divisor change voids the interval in flight
		if (SRST || (BAUD_DIVISOR != $past(BAUD_DIVISOR))) begin
			gap_ok <= 1'b0;
		end else if (pre_tick) begin
			gap_ok <= 1'b1;
		end
	end

	sequence s_load;
		can_load && TRANSMIT_ENABLE_BIT;
	endsequence
	sequence s_start;
		!TXD_OUT && TXD_OE;
	endsequence

	a_baud_gap: assert property (gap_ok && pre_tick && $stable(BAUD_DIVISOR) // RQ1
		|-> gap == {1'b0, BAUD_DIVISOR})
		else $error("baud tick spacing wrong");
	a_clk_master: assert property (m_run && pre_tick // RQ3
		|=> SERIAL_CLOCK_OUT == !$past(SERIAL_CLOCK_OUT))
		else $error("master clock did not toggle on tick");
	a_clk_async: assert property (!SYNC_MODE_SELECT |-> !SERIAL_CLOCK_OE) // RQ6
		else $error("clock pin driven in async mode");
	a_start_low: assert property (s_load |=> s_start) // RQ12
		else $error("frame did not open with low start bit");
	a_idle_high: assert property (!busy |-> TXD_OUT) // RQ12
		else $error("idle line not high");
	a_parity_bit: assert property (fmt.par_en && can_load
		|-> frame[fmt.nbits + 4'h1] == ((^(rd_if.data & par_mask)) != fmt.par_odd)) // RQ14
		else $error("parity bit wrong");
	a_empty_set: assert property ($rose(buf_empty) |=> TX_BUFFER_EMPTY_FLAG) // RQ19
		else $error("empty flag not set");
	a_done_set: assert property (txc_set |=> TX_COMPLETE_FLAG ##0 !busy) // RQ21
		else $error("complete flag not set after last stop");
	a_hold_pin: assert property (busy && !TRANSMIT_ENABLE_BIT |-> TXD_OE) // RQ23
		else $error("pin released during frame");
	a_empty_irq: assert property (TX_BUFFER_EMPTY_FLAG && TX_EMPTY_INT_ENABLE
		&& GLOBAL_INT_ENABLE |-> TX_EMPTY_IRQ) // RQ20
		else $error("empty interrupt missing");
	a_done_irq: assert property (!TX_COMPLETE_FLAG |-> !TX_COMPLETE_IRQ) // RQ22
		else $error("complete interrupt without flag");
endmodule

// ### verif/tb_usart_clockgen_transmitter.sv
// Self-checking bench of the serial transmitter top with a line receiver model
// Assumes 40 MHz clock, divisor kept small so frames stay short
`timescale 1ns/100ps
module tb_usart_clockgen_transmitter;
	// -------------------------------------------------------------
	// Signals
	// -------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sz;
		logic [1:0] pm;
		logic       st;
		logic       dx;
		logic [8:0] d;
	} uctx_row_s;

	logic        SYS_CLK, SRST, SYNC_MODE_SELECT, SPI_MODE_SELECT, MASTER_SELECT;
	logic        DOUBLE_SPEED_SELECT, CLOCK_POLARITY_SELECT, STOP_BITS_SELECT;
	logic        TRANSMIT_ENABLE_BIT, SEL_OUTPUT_ENABLE, TX_NINTH_BIT, DATA_WR, STATUS_WR;
	logic        STATUS_WR_EMPTY, STATUS_WR_DONE, DONE_INT_ACK, GLOBAL_INT_ENABLE;
	logic        TX_EMPTY_INT_ENABLE, TX_COMPLETE_INT_ENABLE, SERIAL_CLOCK_IN, SLAVE_SEL_IN;
	logic [2:0]  CHAR_SIZE_FIELD;
	logic [1:0]  PARITY_MODE_FIELD;
	logic [11:0] BAUD_DIVISOR;
	logic [7:0]  DATA_IN;
	logic        DATA_READY, TX_BUFFER_EMPTY_FLAG, TX_COMPLETE_FLAG, TX_EMPTY_IRQ;
	logic        TX_COMPLETE_IRQ, TXD_OUT, TXD_OE, SERIAL_CLOCK_OUT, SERIAL_CLOCK_OE;
	logic        SLAVE_SEL_OUT, SLAVE_SEL_OE, BAUD_TICK, SAMPLE_EDGE;
	logic [3:0]  FRAME_DATA_BITS;
	logic [7:0]  p_bit;
	logic [3:0]  p_nb;
	logic        p_par, p_st;
	logic [12:0] p_frame;
	logic [7:0]  p_cnt;
	int          error_cnt, checked, cyc, t, base;
	uctx_row_s   rows [6];

	uctx_top uctx_top_i (.*);

	uctx_peer uctx_peer_i (.clk(SYS_CLK), .line(TXD_OUT), .bit_cyc(p_bit), .nbits(p_nb),
		.par_en(p_par), .stop2(p_st), .frame(p_frame), .count(p_cnt));

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			error_cnt++;
		end
	endtask

	task automatic test_done;
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	function automatic int nb_of(input logic [2:0] sz);
		return (sz == 3'h7) ? 9 : ((sz < 3'h4) ? sz + 5 : 8);
	endfunction

	function automatic logic [12:0] exp_frame(input uctx_row_s r);
		int i;
		int p;
		logic [12:0] f;
		logic par;
		f = 13'h0000;
		p = 1;
		par = r.pm[0];
		for (i = 0; i < nb_of(r.sz); i++) begin
			f[p] = r.d[i];
			par ^= r.d[i];
			p++;
		end
		if (r.pm[1]) begin
			f[p] = par;
			p++;
		end
		f[p] = 1'b1;
		if (r.st) f[p + 1] = 1'b1;
		return f;
	endfunction

	// Strobe lasts one cycle, since every cycle it is high with ready set is a write
	// ninth bit set one cycle before the data write
	task automatic send(input logic [8:0] w);
		@(posedge SYS_CLK);
		TX_NINTH_BIT <= w[8];
		@(posedge SYS_CLK);
		DATA_WR <= 1'b1;
		DATA_IN <= w[7:0];
		@(posedge SYS_CLK);
		DATA_WR <= 1'b0;
	endtask

	task automatic wait_frame(input int n);
		t = 0;
		while (p_cnt != n[7:0] && t < 2000) begin
			@(negedge SYS_CLK);
			t++;
		end
		chk("frame count", p_cnt, n[15:0]);
	endtask

	task automatic status_wr(input logic e, input logic d);
		@(posedge SYS_CLK);
		{STATUS_WR, STATUS_WR_EMPTY, STATUS_WR_DONE} <= {1'b1, e, d};
		@(posedge SYS_CLK);
		STATUS_WR <= 1'b0;
		@(negedge SYS_CLK);
	endtask

	// -------------------------------------------------------------
	// Clock and timeout
	// -------------------------------------------------------------
	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end

	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			test_done;
		end
	end

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	initial begin
		{SYNC_MODE_SELECT, SPI_MODE_SELECT, MASTER_SELECT, DOUBLE_SPEED_SELECT} = 4'h0;
		{CLOCK_POLARITY_SELECT, STOP_BITS_SELECT, SEL_OUTPUT_ENABLE, TX_NINTH_BIT} = 4'h0;
		{DATA_WR, STATUS_WR, STATUS_WR_EMPTY, STATUS_WR_DONE, DONE_INT_ACK} = 5'h00;
		{CHAR_SIZE_FIELD, PARITY_MODE_FIELD, DATA_IN, SERIAL_CLOCK_IN} = 14'h0000;
		{SRST, TRANSMIT_ENABLE_BIT, GLOBAL_INT_ENABLE, SLAVE_SEL_IN} = 4'hF;
		{TX_EMPTY_INT_ENABLE, TX_COMPLETE_INT_ENABLE} = 2'h3;
		BAUD_DIVISOR = 12'h001;
		{p_bit, p_nb, p_par, p_st} = {8'h20, 4'h5, 2'h0};
		{error_cnt, checked, cyc} = 96'h0;
		rows = '{'{3'h0, 2'h0, 1'b0, 1'b0, 9'h015}, '{3'h1, 2'h2, 1'b1, 1'b0, 9'h02A},
			'{3'h2, 2'h3, 1'b0, 1'b1, 9'h05B}, '{3'h3, 2'h2, 1'b0, 1'b1, 9'h0C3},
			'{3'h7, 2'h3, 1'b1, 1'b0, 9'h1A5}, '{3'h5, 2'h0, 1'b0, 1'b0, 9'h1FF}};
		repeat (3) @(posedge SYS_CLK);
		SRST <= 1'b0;
		@(negedge SYS_CLK);
		chk("idle line", TXD_OUT, 1);
		// Pin enable is registered, so it follows one edge later
		@(negedge SYS_CLK);
		chk("pin owned", TXD_OE, 1);
		chk("empty rst", TX_BUFFER_EMPTY_FLAG, 1);
		chk("done rst", TX_COMPLETE_FLAG, 0);
		chk("ready rst", DATA_READY, 1);
		chk("async pin", SERIAL_CLOCK_OE, 0);
		// Format table, one frame each; line idles before format changes
		foreach (rows[k]) begin
			repeat (64) @(posedge SYS_CLK);
			{CHAR_SIZE_FIELD, PARITY_MODE_FIELD, STOP_BITS_SELECT} <= rows[k][15:10];
			DOUBLE_SPEED_SELECT <= rows[k].dx;
			{p_bit, p_nb} <= {(rows[k].dx ? 8'h10 : 8'h20), 4'(nb_of(rows[k].sz))};
			{p_par, p_st} <= {rows[k].pm[1], rows[k].st};
			send(rows[k].d);
			wait_frame(k + 1);
			chk("frame", p_frame, exp_frame(rows[k]));
			chk("data bits", FRAME_DATA_BITS, nb_of(rows[k].sz));
		end
		// Fill both entries behind a running frame, then one refused write
		repeat (64) @(posedge SYS_CLK);
		base = p_cnt;
		send(9'h011);
		t = 0;
		while (TXD_OUT !== 1'b0 && t < 100) begin
			@(negedge SYS_CLK);
			t++;
		end
		send(9'h022);
		send(9'h033);
		@(negedge SYS_CLK);
		chk("full", DATA_READY, 0);
		chk("empty low", TX_BUFFER_EMPTY_FLAG, 0);
		chk("empty irq", TX_EMPTY_IRQ, 0);
		send(9'h044);
		for (int i = 1; i <= 3; i++) begin
			wait_frame(base + i);
			chk("burst", p_frame, exp_frame({7'h50, 9'(i * 17)}));
		end
		repeat (100) @(negedge SYS_CLK);
		chk("refused", p_cnt, base + 3);
		chk("empty set", TX_BUFFER_EMPTY_FLAG, 1);
		chk("done set", TX_COMPLETE_FLAG, 1);
		chk("empty irq", TX_EMPTY_IRQ, 1);
		chk("done irq", TX_COMPLETE_IRQ, 1);
		@(posedge SYS_CLK);
		GLOBAL_INT_ENABLE <= 1'b0;
		@(negedge SYS_CLK);
		chk("irq mask", {TX_EMPTY_IRQ, TX_COMPLETE_IRQ}, 0);
		@(posedge SYS_CLK);
		{GLOBAL_INT_ENABLE, DONE_INT_ACK} <= 2'h3;
		@(posedge SYS_CLK);
		DONE_INT_ACK <= 1'b0;
		@(negedge SYS_CLK);
		chk("done ack", {TX_COMPLETE_FLAG, TX_COMPLETE_IRQ}, 0);
		status_wr(1'b0, 1'b1);
		chk("empty zero", {TX_BUFFER_EMPTY_FLAG, TX_EMPTY_IRQ}, 0);
		chk("done one", TX_COMPLETE_FLAG, 0);
		status_wr(1'b1, 1'b1);
		chk("empty one", TX_BUFFER_EMPTY_FLAG, 0);
		// Clock generator in async and sync master modes
		@(posedge SYS_CLK);
		BAUD_DIVISOR <= 12'h003;
		@(negedge SYS_CLK);
		t = 0;
		while (BAUD_TICK !== 1'b1 && t < 50) begin
			@(negedge SYS_CLK);
			t++;
		end
		t = 0;
		do begin
			@(negedge SYS_CLK);
			t++;
		end while (BAUD_TICK !== 1'b1 && t < 50);
		chk("tick gap", 16'(t), 4);
		@(posedge SYS_CLK);
		{SYNC_MODE_SELECT, MASTER_SELECT} <= 2'h3;
		repeat (4) @(negedge SYS_CLK);
		chk("clk out", SERIAL_CLOCK_OE, 1);
		t = 0;
		while (SERIAL_CLOCK_OUT !== 1'b1 && t < 50) begin
			@(negedge SYS_CLK);
			t++;
		end
		t = 0;
		while (SERIAL_CLOCK_OUT === 1'b1 && t < 50) begin
			@(negedge SYS_CLK);
			t++;
		end
		chk("clk high", 16'(t), 4);
		@(posedge SYS_CLK);
		{SPI_MODE_SELECT, SEL_OUTPUT_ENABLE} <= 2'h3;
		@(negedge SYS_CLK);
		chk("sel out", SLAVE_SEL_OE, 1);
		@(posedge SYS_CLK);
		MASTER_SELECT <= 1'b0;
		@(negedge SYS_CLK);
		chk("slave pins", {SLAVE_SEL_OE, SERIAL_CLOCK_OE}, 0);
		// peer clock held eight cycles per level, well under a quarter
		@(posedge SYS_CLK);
		{SERIAL_CLOCK_IN, SLAVE_SEL_IN} <= 2'h2;
		repeat (8) @(posedge SYS_CLK);
		SERIAL_CLOCK_IN <= 1'b0;
		repeat (4) @(negedge SYS_CLK);
		chk("smp edge", SAMPLE_EDGE, 1);
		@(negedge SYS_CLK);
		chk("smp once", SAMPLE_EDGE, 0);
		@(posedge SYS_CLK);
		{SYNC_MODE_SELECT, SPI_MODE_SELECT, SEL_OUTPUT_ENABLE} <= 3'h0;
		BAUD_DIVISOR <= 12'h001;
		// Disable while a frame is on the line
		repeat (8) @(posedge SYS_CLK);
		base = p_cnt;
		send(9'h0A5);
		repeat (40) @(posedge SYS_CLK);
		TRANSMIT_ENABLE_BIT <= 1'b0;
		@(negedge SYS_CLK);
		chk("oe held", TXD_OE, 1);
		wait_frame(base + 1);
		chk("last", p_frame, exp_frame({7'h50, 9'h0A5}));
		repeat (80) @(negedge SYS_CLK);
		chk("oe off", TXD_OE, 0);
		test_done;
	end
endmodule

// ### verif/uctx_peer.sv
// Far-end partner: asynchronous frame receiver on the serial data line
// Assumes the bench sets bit length and format while the line idles
`timescale 1ns/100ps
module uctx_peer (
	input  wire logic        clk,
	input  wire logic        line,
	input  wire logic [7:0]  bit_cyc,
	input  wire logic [3:0]  nbits,
	input  wire logic        par_en,
	input  wire logic        stop2,
	output logic      [12:0] frame,
	output logic      [7:0]  count
);
	// -------------------------------------------------------------
	// Frame capture
	// -------------------------------------------------------------
	initial begin
		count = 8'h00;
		frame = 13'h0000;
	end

	always begin : rx
		int n;
		int i;
		@(negedge line);
		n = 2 + nbits + par_en + stop2;
		frame = 13'h0000;
		// Mid-bit sampling tolerates the start bit jitter of one tick
		repeat (bit_cyc / 2) @(posedge clk);
		for (i = 0; i < n; i++) begin
			frame[i] = line;
			if (i < n - 1) repeat (bit_cyc) @(posedge clk);
		end
		count = count + 8'h01;
	end
endmodule
